// File: verilog/char_lcd_engine.sv
// character display instruction engine with classic Wishbone register access
// Summary of operation
// [RULE_01] clear display writes blank code 20H into every display memory cell
// [RULE_02] after clear the pointer is zero and any display shift is undone
// [RULE_03] clear forces step direction to increment, shift enable kept
// [RULE_04] return home zeroes pointer and shift, memory contents untouched
// [RULE_05] each memory write or read steps the pointer by one per direction
// [RULE_06] cursor position follows the pointer, right on increment, left on decrement
// [RULE_07] with shift enabled a display write shifts left on increment, right otherwise
// [RULE_08] display reads and all glyph accesses never shift the display
// [RULE_09] display off blanks output, memory kept and shown again at once
// [RULE_10] cursor drawn on row 8 for small font, row 11 for big font
// [RULE_11] blink alternates blank and normal every 409.6 ms at 250 kHz reference
// [RULE_12] cursor or display shift moves one place, cursor wraps line one to two
// [RULE_13] display shift moves both lines together, only horizontally
// [RULE_14] a pure display shift leaves the pointer unchanged
// [RULE_15] width bit selects 8-bit transfers or 4-bit transfers on upper lines
// [RULE_16] function set first, later ones only act when width changes
// [RULE_17] function set also latches line count and font
// [RULE_18] glyph address instruction loads six bits, later data goes to glyph memory
// [RULE_19] clear is recognised only for byte 01H
// [RULE_20] display control holds display, cursor and blink bits in low three bits
// [RULE_21] busy is shown while an instruction runs; writes meanwhile are ignored
// [RULE_22] in 4-bit mode high nibble first, byte acted on after both halves
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module char_lcd_engine #(
   parameter int BLINK_CYCLES = char_lcd_pkg::BLINK_REF_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             displayOn,
   output logic             cursorOn,
   output logic             blinkBlank,
   output logic [3:0]       cursorRow,
   output logic [6:0]       cursorAddr,
   output logic [5:0]       shiftOffset,
   output logic             twoLine,
   output logic             bigFont,
   output logic             busy
);
   import char_lcd_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // next pointer value; two-line mode hops the gap between the lines
   function automatic logic [6:0] stepAddr(input logic [6:0] a, input logic up,
                                           input logic two, input logic cg);
      logic [6:0] r;
      r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
      if (cg)
         r = {1'b0, r[5:0]};
      else if (two && up && a == L1_LAST)
         r = L2_FIRST;
      else if (two && up && a == L2_LAST)
         r = HOME_ADDR;
      else if (two && !up && a == L2_FIRST)
         r = L1_LAST;
      else if (two && !up && a == HOME_ADDR)
         r = L2_LAST;
      else if (!two && up && a == ONE_LAST)
         r = HOME_ADDR;
      else if (!two && !up && a == HOME_ADDR)
         r = ONE_LAST;
      return r;
   endfunction

   // display memory cell of a pointer value
   function automatic logic [6:0] ddIndex(input logic [6:0] a, input logic two);
      return (two && a[6]) ? 7'(7'(LINE_LEN) + {1'b0, a[5:0]}) : a;
   endfunction

   // one shared offset for both lines keeps the shift purely horizontal
   function automatic logic [5:0] shiftStep(input logic [5:0] s, input logic left);
      logic [5:0] r;
      if (left)
         r = (s == SHIFT_LAST) ? 6'h00 : 6'(s + 6'h01);
      else
         r = (s == 6'h00) ? SHIFT_LAST : 6'(s - 6'h01);
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   eng_state_t state_q;
   logic [7:0] display_data_memory_q [DD_DEPTH];
   logic [7:0] glyph_pattern_memory_q [CG_DEPTH];
   logic [6:0] ac_q;
   logic [5:0] shift_q;
   logic [6:0] clrIdx_q;
   logic [7:0] pend_q;
   logic       pendData_q;
   logic       stepUp_q, shiftEn_q, dispOn_q, cursorOn_q, blinkOn_q;
   logic       wide8_q, twoLine_q, bigFont_q, cgMode_q, fnDone_q, busy_q;
   logic       ack_q, wrHalf_q, rdHalf_q;
   logic [3:0] hiNib_q;
   logic [31:0] dat_q;
   logic [16:0] blinkCnt_q;
   logic       blinkPhase_q, blinkBlank_q;
   logic [3:0] cursorRow_q;
   logic       req, wrStrobe, rdData, byteValid, rdStep;
   logic [7:0] byteVal, memRd;

   // ----------------------------------------------------------------
   // bus request decode and byte assembly
   // ----------------------------------------------------------------
   // only the first cycle of a request acts, so a held request counts once
   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign wrStrobe = req && wb_we_i && wb_sel_i[0] && !busy_q
                     && (wb_adr_i == REG_INSTR || wb_adr_i == REG_DATA);  // see [RULE_21]
   assign rdData   = req && !wb_we_i && wb_adr_i == REG_DATA && !busy_q;
   assign byteValid = wrStrobe && (wide8_q || wrHalf_q);            // see [RULE_22]
   assign byteVal   = wide8_q ? wb_dat_i[7:0]
                              : {hiNib_q, wb_dat_i[7:4]};           // see [RULE_15]
   assign rdStep    = rdData && (wide8_q || rdHalf_q);
   assign memRd     = cgMode_q ? glyph_pattern_memory_q[ac_q[5:0]]
                               : display_data_memory_q[ddIndex(ac_q, twoLine_q)];

   // acknowledge one cycle after the request, read data captured with it
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= req;
         dat_q <= 32'h0000_0000;  // unmapped addresses read as zero
         if (req && !wb_we_i)
            unique case (wb_adr_i)
               REG_INSTR: dat_q <= {24'h00_0000, busy_q, ac_q};
               REG_DATA:  dat_q <= {24'h00_0000, wide8_q ? memRd : rdHalf_q ? {memRd[3:0], 4'h0}
                                    : {memRd[7:4], 4'h0}};         // see [RULE_15]
               REG_MODE:  dat_q <= {22'h00_0000, fnDone_q, cgMode_q, bigFont_q,
                                    twoLine_q, wide8_q, blinkOn_q, cursorOn_q,
                                    dispOn_q, shiftEn_q, stepUp_q};
               default:   dat_q <= 32'h0000_0000;
            endcase
      end
   end

   // nibble tracking; the first half only parks the high nibble
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wrHalf_q <= 1'b0;
         rdHalf_q <= 1'b0;
         hiNib_q  <= 4'h0;
      end
      else
      begin
         if (wide8_q)
            wrHalf_q <= 1'b0;
         else if (wrStrobe)
         begin
            wrHalf_q <= !wrHalf_q;               // see [RULE_22]
            if (!wrHalf_q)
               hiNib_q <= wb_dat_i[7:4];
         end
         if (wide8_q)
            rdHalf_q <= 1'b0;
         else if (rdData)
            rdHalf_q <= !rdHalf_q;
      end
   end

   // ----------------------------------------------------------------
   // instruction engine
   // ----------------------------------------------------------------
   // a byte is parked in idle and carried out in exec; busy covers both
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q    <= ST_IDLE;
         busy_q     <= 1'b0;
         pend_q     <= 8'h00;
         pendData_q <= 1'b0;
         clrIdx_q   <= 7'h00;
         ac_q       <= HOME_ADDR;
         shift_q    <= 6'h00;
         stepUp_q   <= 1'b1;
         shiftEn_q  <= 1'b0;
         dispOn_q   <= 1'b0;
         cursorOn_q <= 1'b0;
         blinkOn_q  <= 1'b0;
         wide8_q    <= 1'b1;
         twoLine_q  <= 1'b0;
         bigFont_q  <= 1'b0;
         cgMode_q   <= 1'b0;
         fnDone_q   <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (byteValid)
               begin
                  pend_q     <= byteVal;
                  pendData_q <= (wb_adr_i == REG_DATA);
                  busy_q     <= 1'b1;            // see [RULE_21]
                  state_q    <= ST_EXEC;
               end
               else if (rdStep)                  // reads never shift, see [RULE_08]
                  ac_q <= stepAddr(ac_q, stepUp_q, twoLine_q, cgMode_q);  // see [RULE_05]
            end
            ST_EXEC:
            begin
               state_q <= ST_IDLE;
               busy_q  <= 1'b0;
               if (pendData_q)
               begin
                  // cursor follows the pointer, see [RULE_06]
                  ac_q <= stepAddr(ac_q, stepUp_q, twoLine_q, cgMode_q);  // see [RULE_05]
                  if (shiftEn_q && !cgMode_q)
                     shift_q <= shiftStep(shift_q, stepUp_q);  // see [RULE_07] [RULE_08]
               end
               else if (!fnDone_q && pend_q[7:5] != 3'b001)
               begin
                  // ignored until the first function set, see [RULE_16]
               end
               else
                  casez (pend_q)
                     8'b1???_????:
                     begin
                        // display address set is not part of this engine
                     end
                     8'b01??_????:
                     begin
                        ac_q     <= {1'b0, pend_q[5:0]};      // see [RULE_18]
                        cgMode_q <= 1'b1;
                     end
                     8'b001?_????:
                     begin
                        if (!fnDone_q || pend_q[FN_WIDE] != wide8_q)  // see [RULE_16]
                        begin
                           fnDone_q  <= 1'b1;
                           wide8_q   <= pend_q[FN_WIDE];      // see [RULE_15]
                           twoLine_q <= pend_q[FN_LINES];     // see [RULE_17]
                           bigFont_q <= pend_q[FN_FONT];
                        end
                     end
                     8'b0001_????:
                     begin
                        if (pend_q[SHF_DISP])                 // see [RULE_13] [RULE_14]
                           shift_q <= shiftStep(shift_q, pend_q[SHF_LEFT]);
                        else                                  // see [RULE_12]
                           ac_q <= stepAddr(ac_q, !pend_q[SHF_LEFT], twoLine_q, cgMode_q);
                     end
                     8'b0000_1???:
                     begin
                        dispOn_q   <= pend_q[DSP_ON];         // see [RULE_20] [RULE_09]
                        cursorOn_q <= pend_q[DSP_CUR];
                        blinkOn_q  <= pend_q[DSP_BLK];
                     end
                     8'b0000_01??:
                     begin
                        stepUp_q  <= pend_q[ENT_DIR];
                        shiftEn_q <= pend_q[ENT_SHF];
                     end
                     8'b0000_001?:
                     begin
                        ac_q     <= HOME_ADDR;                // see [RULE_04]
                        shift_q  <= 6'h00;
                        cgMode_q <= 1'b0;
                     end
                     8'b0000_0001:
                     begin
                        clrIdx_q <= 7'h00;                    // see [RULE_19]
                        busy_q   <= 1'b1;
                        state_q  <= ST_CLEAR;
                     end
                     default:
                     begin
                        // 00H does nothing
                     end
                  endcase
            end
            ST_CLEAR:
            begin
               // one cell per cycle: 80 clear cycles, 81 busy with exec, no wide write port needed
               clrIdx_q <= 7'(clrIdx_q + 7'h01);
               if (clrIdx_q == CLR_LAST)
               begin
                  state_q  <= ST_IDLE;
                  busy_q   <= 1'b0;
                  ac_q     <= HOME_ADDR;                      // see [RULE_02]
                  shift_q  <= 6'h00;
                  cgMode_q <= 1'b0;
                  stepUp_q <= 1'b1;                           // see [RULE_03]
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // memories, no reset: contents stay across display off
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (state_q == ST_CLEAR)
         display_data_memory_q[clrIdx_q] <= BLANK_CODE;                     // see [RULE_01]
      else if (state_q == ST_EXEC && pendData_q && !cgMode_q)
         display_data_memory_q[ddIndex(ac_q, twoLine_q)] <= pend_q;
      if (state_q == ST_EXEC && pendData_q && cgMode_q)
         glyph_pattern_memory_q[ac_q[5:0]] <= pend_q;
   end

   // ----------------------------------------------------------------
   // cursor presentation and blink timing
   // ----------------------------------------------------------------
   // the blink period is a cycle count, so it scales with the clock rate
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         blinkCnt_q   <= 17'h0_0000;
         blinkPhase_q <= 1'b0;
         blinkBlank_q <= 1'b0;
         cursorRow_q  <= ROW_SMALL;
      end
      else
      begin
         if (blinkCnt_q == 17'(BLINK_CYCLES - 1))
         begin
            blinkCnt_q   <= 17'h0_0000;
            blinkPhase_q <= !blinkPhase_q;                    // see [RULE_11]
         end
         else
            blinkCnt_q <= 17'(blinkCnt_q + 17'h0_0001);
         blinkBlank_q <= blinkOn_q && blinkPhase_q;
         cursorRow_q  <= bigFont_q ? ROW_BIG : ROW_SMALL;     // see [RULE_10]
      end
   end

   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = dat_q;
   assign displayOn   = dispOn_q;                             // see [RULE_09]
   assign cursorOn    = cursorOn_q;
   assign blinkBlank  = blinkBlank_q;
   assign cursorRow   = cursorRow_q;
   assign cursorAddr  = ac_q;
   assign shiftOffset = shift_q;
   assign twoLine     = twoLine_q;
   assign bigFont     = bigFont_q;
   assign busy        = busy_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_CLEAR_BLANK: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_01]
      state_q == ST_CLEAR |=> display_data_memory_q[$past(clrIdx_q)] == BLANK_CODE)
      else $error("clear left a cell non-blank");
   AST_CLEAR_END: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_02]
      (state_q == ST_CLEAR && clrIdx_q == CLR_LAST)
      |=> ac_q == HOME_ADDR && shift_q == 6'h00 && state_q == ST_IDLE)
      else $error("clear did not home pointer and shift");
   AST_CLEAR_DIR: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_03]
      (state_q == ST_CLEAR && clrIdx_q == CLR_LAST)
      |=> stepUp_q && shiftEn_q == $past(shiftEn_q))
      else $error("clear set wrong entry bits");
   AST_HOME: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_04]
      (state_q == ST_EXEC && !pendData_q && fnDone_q && pend_q[7:1] == 7'h01)
      |=> ac_q == HOME_ADDR && shift_q == 6'h00)
      else $error("return home failed");
   AST_GLYPH_STEP: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_05]
      (state_q == ST_EXEC && pendData_q && cgMode_q)
      |=> ac_q[5:0] == 6'($past(ac_q[5:0]) + ($past(stepUp_q) ? 6'h01 : 6'h3F)))
      else $error("glyph write did not step the pointer");
   AST_GLYPH_NO_SHIFT: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_08]
      (state_q == ST_EXEC && pendData_q && cgMode_q) |=> $stable(shift_q))
      else $error("glyph access shifted the display");
   AST_DISP_SHIFT_AC: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_14]
      (state_q == ST_EXEC && !pendData_q && pend_q[7:4] == 4'h1 && pend_q[SHF_DISP])
      |=> $stable(ac_q))
      else $error("display shift moved the pointer");
   AST_FN_FIRST: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_16]
      (state_q == ST_EXEC && !pendData_q && !fnDone_q && pend_q[7:5] != 3'b001)
      |=> $stable(dispOn_q) && $stable(ac_q) && state_q == ST_IDLE)
      else $error("instruction acted before function set");
   AST_BUSY: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_21]
      (state_q == ST_IDLE && byteValid) |=> busy_q ##1 (busy_q == (state_q != ST_IDLE)))
      else $error("busy not shown during execution");
   AST_NIBBLE: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_22]
      (wrStrobe && !wide8_q && !wrHalf_q) |-> !byteValid ##1 wrHalf_q)
      else $error("first nibble acted on alone");
   AST_ROW: assert property (@(posedge sys_clk) disable iff (rst)  // see [RULE_10]
      $changed(bigFont_q) |=> cursorRow_q == ($past(bigFont_q) ? ROW_BIG : ROW_SMALL))
      else $error("cursor row does not match font");
endmodule

// File: verilog/char_lcd_pkg.sv
// constants, register map and types of the character display instruction engine
package char_lcd_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on the bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_INSTR = 8'h00;  // write instruction, read busy and pointer
   localparam logic [7:0] REG_DATA  = 8'h04;  // write or read memory at the pointer
   localparam logic [7:0] REG_MODE  = 8'h08;  // read-only mode bits
   localparam int BUSY_BIT = 7;
   // mode register field positions
   localparam int MODE_STEP_UP   = 0;
   localparam int MODE_SHIFT_EN  = 1;
   localparam int MODE_DISP_ON   = 2;
   localparam int MODE_CURSOR_ON = 3;
   localparam int MODE_BLINK_ON  = 4;
   localparam int MODE_WIDE8     = 5;
   localparam int MODE_TWO_LINE  = 6;
   localparam int MODE_BIG_FONT  = 7;
   localparam int MODE_GLYPH_SEL = 8;
   localparam int MODE_FN_DONE   = 9;
   // ----------------------------------------------------------------
   // memories and addressing
   // ----------------------------------------------------------------
   localparam int DD_DEPTH = 80;
   localparam int CG_DEPTH = 64;
   localparam int LINE_LEN = 40;
   localparam logic [7:0] BLANK_CODE  = 8'h20;
   localparam logic [6:0] ONE_LAST    = 7'h4F;  // last address, one line
   localparam logic [6:0] L1_LAST     = 7'h27;  // last address of line one
   localparam logic [6:0] L2_FIRST    = 7'h40;  // first address of line two
   localparam logic [6:0] L2_LAST     = 7'h67;  // last address of line two
   localparam logic [6:0] HOME_ADDR   = 7'h00;
   localparam logic [5:0] SHIFT_LAST  = 6'h27;  // offsets run 0 .. 39
   localparam logic [6:0] CLR_LAST    = 7'h4F;
   // cursor rows, counted from zero
   localparam logic [3:0] ROW_SMALL = 4'h7;     // 8th row of 5x8
   localparam logic [3:0] ROW_BIG   = 4'hA;     // 11th row of 5x10
   // instruction bit positions
   localparam int ENT_DIR = 1;
   localparam int ENT_SHF = 0;
   localparam int DSP_ON  = 2;
   localparam int DSP_CUR = 1;
   localparam int DSP_BLK = 0;
   localparam int SHF_DISP = 3;
   localparam int SHF_LEFT = 2;
   localparam int FN_WIDE  = 4;
   localparam int FN_LINES = 3;
   localparam int FN_FONT  = 2;
   // ----------------------------------------------------------------
   // blink timing: 409.6 ms at a 250 kHz reference, i.e. a cycle count
   // ----------------------------------------------------------------
   localparam int BLINK_TIME_US   = 409600;
   localparam int BLINK_REF_KHZ   = 250;
   localparam int BLINK_REF_CYCLES = BLINK_TIME_US * BLINK_REF_KHZ / 1000;
   // ----------------------------------------------------------------
   // engine states, Gray along idle -> exec -> clear
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_CLEAR = 2'b11
   } eng_state_t;
endpackage

// File: test/host_bus_model.sv
// host processor model issuing instruction and data bytes over classic Wishbone
`timescale 1ns/100ps
module host_bus_model
   import char_lcd_pkg::*;
(
   sys_clk,
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_adr_i,
   wb_sel_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o
);
   input  wire logic        sys_clk;
   output logic             wb_cyc_i = 1'b0;
   output logic             wb_stb_i = 1'b0;
   output logic             wb_we_i  = 1'b0;
   output logic      [7:0]  wb_adr_i = 8'h00;
   output logic      [3:0]  wb_sel_i = 4'h0;
   output logic      [31:0] wb_dat_i = 32'h0;
   input  wire logic [31:0] wb_dat_o;
   input  wire logic        wb_ack_o;
   logic                    nib = 1'b0;  // set by the bench once 4-bit mode is chosen
   // one classic cycle, held until ack is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'hF};
      wb_dat_i <= {24'h0, d};
      // no own limit: only the bench's cycle ceiling ends a hung wait
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   // poll busy so no write is dropped by a running instruction
   task idle;
      logic [31:0] r;
      do xfer(1'b0, REG_INSTR, 8'h00, r); while (r[BUSY_BIT] !== 1'b0);
   endtask
   task half(input logic [7:0] a, input logic [3:0] v);
      logic [31:0] r;
      xfer(1'b1, a, {v, 4'h0}, r);  // nibble rides on the upper lines
   endtask
   // whole byte, high nibble first when the bus is narrow
   task send(input logic isData, input logic [7:0] b);
      logic [31:0] r;
      idle();
      if (nib)
      begin
         half(isData ? REG_DATA : REG_INSTR, b[7:4]);
         half(isData ? REG_DATA : REG_INSTR, b[3:0]);
      end
      else
         xfer(1'b1, isData ? REG_DATA : REG_INSTR, b, r);
      idle();
   endtask
endmodule

// File: test/char_lcd_instruction_engine_test.sv
// self-checking bench of the character display instruction engine
`timescale 1ns/100ps
module char_lcd_instruction_engine_test;
   import char_lcd_pkg::*;
   logic        sys_clk, rst, wbCyc, wbStb, wbWe, wbAck, displayOn, cursorOn, blinkBlank;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel, cursorRow;
   logic [31:0] wbDatI, wbDatO, rv;
   logic [6:0]  cursorAddr;
   logic [5:0]  shiftOffset;
   logic        twoLine, bigFont, busy;
   int          miscompares = 0, checks = 0, cycles = 0;
   char_lcd_engine #(.BLINK_CYCLES(8)) DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .displayOn(displayOn), .cursorOn(cursorOn),
      .blinkBlank(blinkBlank), .cursorRow(cursorRow), .cursorAddr(cursorAddr),
      .shiftOffset(shiftOffset), .twoLine(twoLine), .bigFont(bigFont), .busy(busy));
   host_bus_model host (.sys_clk(sys_clk), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (miscompares == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task fn_first;
      host.send(1'b0, 8'h0F);
      chk(displayOn, 1'b0);
      host.send(1'b0, 8'h38);
      chk({twoLine, bigFont, cursorRow}, {2'b10, 4'h7});
      host.send(1'b0, 8'h0F);
      chk({displayOn, cursorOn}, 2'b11);
   endtask
   // phase length measured between two toggles, not from an unknown start
   task blink_rate;
      logic b;
      int   n;
      b = blinkBlank;
      n = 0;
      do @(posedge sys_clk); while (blinkBlank === b && ++n < 40);
      b = blinkBlank;
      n = 1;  // the edge that saw the toggle is the first of the phase
      do @(posedge sys_clk); while (blinkBlank === b && ++n < 40);
      chk(n, 8);
   endtask
   task clear_home;
      host.send(1'b0, 8'h05);
      host.send(1'b1, 8'h41);
      chk(shiftOffset, 6'h27);
      host.send(1'b0, 8'h01);
      chk({busy, cursorAddr, shiftOffset}, 14'h0);
      host.xfer(1'b0, REG_MODE, 8'h00, rv);
      chk(rv[1:0], 2'b11);
      host.xfer(1'b0, REG_DATA, 8'h00, rv);
      chk(rv[7:0], BLANK_CODE);
      chk({cursorAddr, shiftOffset}, {7'h01, 6'h00});
      host.send(1'b1, 8'h41);
      chk({cursorAddr, shiftOffset}, {7'h02, 6'h01});
      host.send(1'b0, 8'h1C);
      chk({cursorAddr, shiftOffset}, {7'h02, 6'h02});
      host.send(1'b0, 8'h02);
      chk({cursorAddr, shiftOffset}, 13'h0);
      host.xfer(1'b0, REG_DATA, 8'h00, rv);
      host.xfer(1'b0, REG_DATA, 8'h00, rv);
      chk(rv[7:0], 8'h41);
      host.send(1'b0, 8'h10);
      chk(cursorAddr, 7'h03);
   endtask
   task narrow_bus;
      host.send(1'b0, 8'h3C);
      chk(bigFont, 1'b0);
      host.send(1'b0, 8'h2C);
      host.nib = 1'b1;
      chk({bigFont, cursorRow}, {1'b1, 4'hA});
      host.half(REG_INSTR, 4'h0);
      host.idle();
      chk(displayOn, 1'b1);
      host.half(REG_INSTR, 4'h8);
      host.idle();
      chk(displayOn, 1'b0);
      host.send(1'b0, 8'h45);
      chk(cursorAddr, 7'h05);
      host.send(1'b1, 8'h5A);
      chk({cursorAddr, shiftOffset}, {7'h06, 6'h00});
      // narrow reads: high nibble then low nibble, both on the upper lines
      host.send(1'b0, 8'h45);
      host.xfer(1'b0, REG_DATA, 8'h00, rv);
      chk({rv[7:0], cursorAddr}, {8'h50, 7'h05});
      host.xfer(1'b0, REG_DATA, 8'h00, rv);
      chk({rv[7:0], cursorAddr}, {8'hA0, 7'h06});
      host.xfer(1'b0, 8'hFC, 8'h00, rv);
      chk(rv, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // clock, reset, sequence and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         end_of_test();
      end
   end
   initial
   begin
      rst = 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      fn_first();
      blink_rate();
      clear_home();
      narrow_bus();
      end_of_test();
   end
endmodule
